// ==== bmh_dev_model.sv ====
// bmh_dev_model: behavioural battery monitor slave on the two-wire bus.
// assumes pulled-up scl and sda; pulls sda low through sda_oe only.
`timescale 1ns/10ps
module bmh_dev_model import bmh_pkg::*; (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic mute,
	output logic      sda_oe
);
	// sleep and divider timing are not modelled; kept only as named values
	localparam int SLEEP_ENTRY_DELAY_NS      = 1000;
	localparam int DIVIDER_PRECHARGE_LEAD_NS = 1000;
	logic [7:0] regs [0:255];
	logic [7:0] sh, tx, snap;
	logic [8:0] ptr = 9'h000;
	logic       act = 1'b0, rd = 1'b0, mnak = 1'b0, snap_ok = 1'b0;
	int         cnt = 0, idx = 0;
	initial begin
		sda_oe = 1'b0;
		foreach (regs[i]) regs[i] = 8'h00;
		regs[1] = 8'h70;
	end
	task automatic store(input logic [8:0] a, input logic [7:0] d);
		case (a)
			9'h001: regs[1] = (regs[1] & 8'h87) | (d & regs[1] & 8'h40) | (d & 8'h38);
			9'h010, 9'h011, 9'h061, 9'h062: regs[a[7:0]] = d;
			default: ;
		endcase
	endtask : store
	always @(negedge sda) if (scl) begin
		act = 1'b1;
		rd = 1'b0;
		mnak = 1'b0;
		snap_ok = 1'b0;
		cnt = 0;
		idx = 0;
	end
	always @(posedge sda) if (scl) begin
		act = 1'b0;
		sda_oe = 1'b0;
	end
	always @(posedge scl) if (act) begin
		if (cnt < 8) sh = {sh[6:0], sda};
		else if (rd && sda) mnak = 1'b1;
		cnt = cnt + 1;
	end
	always @(negedge scl) if (act) begin
		sda_oe = 1'b0;
		if (cnt == 8) begin
			if (idx == 0) begin
				rd = sh[0];
				sda_oe = (sh[7:1] == DEV_ADDR) && !mute;
				act = sda_oe;
			end else if (!rd) begin
				sda_oe = 1'b1;
				if (idx == 1) ptr = {1'b0, sh};
				else begin
					store(ptr, sh);
					ptr = ptr + 9'h001;
				end
			end
			idx = idx + 1;
		end else if (cnt == 9) cnt = 0;
		if (rd && act && !mnak && cnt < 8) begin
			if (cnt == 0) begin
				tx = ptr[8] ? 8'hff : ((ptr[0] && snap_ok) ? snap : regs[ptr[7:0]]);
				snap = regs[ptr[7:0] | 8'h01];
				snap_ok = !ptr[0];
				ptr = ptr + 9'h001;
			end
			sda_oe = ~tx[7 - cnt];
		end
	end
endmodule : bmh_dev_model

// ==== bmh_master.sv ====
// bmh_master: two-wire bus master that reads and writes the battery monitor registers.
// assumes a plain register port from software and pull-ups on scl and sda.
`timescale 1ns/10ps
module bmh_master
	import bmh_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire bmh_bus_type  bus,
	output logic [7:0]        rdata,
	input  wire logic         scl_i,
	input  wire logic         sda_i,
	output bmh_pins_type      pins,
	output logic              busy
);
	// ************************************************
	// state
	// ************************************************
	typedef struct packed {
		bmh_state_type st;
		logic [QCNT_W-1:0] qcnt;
		logic [1:0]  phase;
		logic [3:0]  bitn;
		logic [7:0]  sh;
		logic [1:0]  bytei;
		logic        rd_op;
		logic        two;
		logic        in_read;
		logic        busy;
		logic        nack;
		logic        done;
		logic [7:0]  ptr;
		logic [7:0]  wd0;
		logic [7:0]  wd1;
		logic [7:0]  rd0;
		logic [7:0]  rd1;
		logic [7:0]  rdata;
		logic        scl_low;
		logic        sda_low;
		logic [2:0]  sda_sync;
		logic        sda_s;
	} bmh_regs_type;

	bmh_regs_type r, nx;

	function automatic logic [7:0] host_read(input bmh_regs_type s, input logic [3:0] a);
		unique case (a)
			HA_POINTER: host_read = s.ptr;
			HA_WDATA0:  host_read = s.wd0;
			HA_WDATA1:  host_read = s.wd1;
			HA_STATUS:  host_read = {5'h00, s.done, s.nack, s.busy};
			HA_RDATA0:  host_read = s.rd0;
			HA_RDATA1:  host_read = s.rd1;
			default:    host_read = 8'h00;
		endcase
	endfunction : host_read

	// byte to send for current byte index
	function automatic logic [7:0] tx_byte(input bmh_regs_type s);
		if (s.bytei == 2'd0)
			tx_byte = {DEV_ADDR, s.in_read ? RW_READ : RW_WRITE};
		else if (s.bytei == 2'd1)
			tx_byte = s.ptr;
		else if (s.bytei == 2'd2)
			tx_byte = s.wd0;
		else
			tx_byte = s.wd1;
	endfunction : tx_byte

	logic last_q;
	logic sending;
	assign last_q  = (r.qcnt == QCNT_W'(QUARTER_CYC - 1));
	assign sending = !(r.in_read && r.bytei != 2'd0);

	// ************************************************
	// next state
	// ************************************************
	always_comb begin
		nx = r;
		nx.rdata = 8'h00;
		// sda sampled via three flops; change taken once last two agree
		nx.sda_sync = {r.sda_sync[1:0], sda_i};
		if (r.sda_sync[2] == r.sda_sync[1])
			nx.sda_s = r.sda_sync[2];
		if (bus.rd)
			nx.rdata = host_read(r, bus.addr);
		if (bus.wr && !r.busy) begin
			unique case (bus.addr)
				HA_POINTER: nx.ptr = bus.wdata;
				HA_WDATA0:  nx.wd0 = bus.wdata;
				HA_WDATA1:  nx.wd1 = bus.wdata;
				HA_CTRL: begin
					if (bus.wdata[CTRL_GO]) begin
						nx.st      = BM_START;
						nx.busy    = 1'b1;
						nx.done    = 1'b0;
						nx.nack    = 1'b0;
						nx.rd_op   = bus.wdata[CTRL_READ];
						nx.two     = bus.wdata[CTRL_TWO];
						nx.in_read = 1'b0;
						nx.bytei   = 2'd0;
						nx.qcnt    = '0;
						nx.phase   = 2'd0;
					end
				end
				default: ;
			endcase
		end
		if (r.st != BM_IDLE) begin
			nx.qcnt = last_q ? '0 : r.qcnt + 1'b1;
			if (last_q)
				nx.phase = r.phase + 2'd1;
		end
		// quarter phases: 0 scl low set data, 1 scl rises, 2 sample, 3 scl falls
		unique case (r.st)
			BM_IDLE: begin
				nx.scl_low = 1'b0;
				nx.sda_low = 1'b0;
			end
			BM_START, BM_RSTART: begin
				if (last_q) begin
					unique case (r.phase)
						2'd0: begin
							nx.sda_low = 1'b0;
							nx.scl_low = (r.st == BM_RSTART);
						end
						2'd1: nx.scl_low = 1'b0;
						2'd2: nx.sda_low = 1'b1;
						2'd3: begin
							nx.scl_low = 1'b1;
							nx.st      = BM_BIT;
							nx.bitn    = 4'd0;
							nx.sh      = {DEV_ADDR, (r.st == BM_RSTART) ? RW_READ : RW_WRITE};
						end
						default: ;
					endcase
				end
			end
			BM_BIT: begin
				if (last_q) begin
					unique case (r.phase)
						2'd0: nx.sda_low = sending ? !r.sh[7] : 1'b0;
						2'd1: nx.scl_low = 1'b0;
						2'd2: nx.sh = {r.sh[6:0], r.sda_s};
						2'd3: begin
							nx.scl_low = 1'b1;
							if (r.bitn == 4'd7)
								nx.st = BM_ACK;
							else
								nx.bitn = r.bitn + 4'd1;
						end
						default: ;
					endcase
				end
			end
			BM_ACK: begin
				if (last_q) begin
					unique case (r.phase)
						2'd0: begin
							// ack our received byte unless it is the last wanted
							if (sending)
								nx.sda_low = 1'b0;
							else if (r.bytei == 2'd1 && r.two)
								nx.sda_low = 1'b1;
							else
								nx.sda_low = 1'b0;
						end
						2'd1: nx.scl_low = 1'b0;
						2'd2: begin
							if (sending && r.sda_s)
								nx.nack = 1'b1;
							if (!sending && r.bytei == 2'd1)
								nx.rd0 = r.sh;
							if (!sending && r.bytei == 2'd2)
								nx.rd1 = r.sh;
						end
						2'd3: begin
							nx.scl_low = 1'b1;
							nx.bytei   = r.bytei + 2'd1;
							nx.bitn    = 4'd0;
							if (r.nack) begin
								nx.st = BM_STOP;
							end else if (r.rd_op && !r.in_read && r.bytei == 2'd1) begin
								nx.st      = BM_RSTART;
								nx.in_read = 1'b1;
								nx.bytei   = 2'd0;
							end else if (r.in_read && r.bytei != 2'd0 &&
							             !(r.bytei == 2'd1 && r.two)) begin
								nx.st = BM_STOP;
							end else if (!r.in_read && (r.bytei == 2'd3 ||
							             (r.bytei == 2'd2 && !r.two))) begin
								nx.st = BM_STOP;
							end else begin
								nx.st = BM_BIT;
								nx.sh = r.in_read ? 8'h00 : tx_byte(r);
								if (!r.in_read && r.bytei == 2'd0)
									nx.sh = r.ptr;
								// flag is write-to-zero: wd0 sent with the pointer on status has it cleared
								else if (!r.in_read && r.bytei == 2'd1 && r.ptr == REG_STATUS_CONFIG)
									nx.sh = r.wd0 & ~(8'h01 << SC_POWER_ON_FLAG);
								else if (!r.in_read && r.bytei == 2'd1)
									nx.sh = r.wd0;
								else if (!r.in_read && r.bytei == 2'd2)
									nx.sh = r.wd1;
							end
						end
						default: ;
					endcase
				end
			end
			BM_STOP: begin
				if (last_q) begin
					unique case (r.phase)
						2'd0: nx.sda_low = 1'b1;
						2'd1: nx.scl_low = 1'b0;
						2'd2: nx.sda_low = 1'b0;
						2'd3: begin
							nx.st   = BM_IDLE;
							nx.busy = 1'b0;
							nx.done = 1'b1;
						end
						default: ;
					endcase
				end
			end
			default: nx.st = BM_IDLE;
		endcase
	end

	// ************************************************
	// registers
	// ************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r <= '{st: BM_IDLE, sda_sync: 3'b111, sda_s: 1'b1, default: '0};
		end else begin
			r <= nx;
		end
	end

	// open-drain: only ever pull low, release for high
	assign pins.scl_o  = 1'b0;
	assign pins.scl_oe = r.scl_low;
	assign pins.sda_o  = 1'b0;
	assign pins.sda_oe = r.sda_low;
	assign rdata       = r.rdata;
	assign busy        = r.busy;
endmodule : bmh_master

// ==== bmh_master_bench.sv ====
// bmh_master_bench: drives bmh_master from its register port against the device model.
// assumes pull-ups on both wires and no other master.
`timescale 1ns/10ps
module bmh_master_bench import bmh_pkg::*;;
	logic         clk;
	logic         resetn;
	bmh_bus_type  bus;
	logic [7:0]   rdata;
	bmh_pins_type pins;
	logic         busy;
	logic         dev_oe;
	logic         dev_mute = 1'b0;
	wire          scl = ~pins.scl_oe;
	wire          sda = ~(pins.sda_oe | dev_oe);
	int           fail_count = 0;
	int           checked = 0;
	int           cycles = 0;
	bmh_master i_bmh_master (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
		.scl_i(scl), .sda_i(sda), .pins(pins), .busy(busy));
	bmh_dev_model i_bmh_dev_model (.scl(scl), .sda(sda), .mute(dev_mute), .sda_oe(dev_oe));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("MISMATCH %0t got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_of_test;
		if (fail_count == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test
	task automatic hwrite(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) bus <= '0;
	endtask : hwrite
	task automatic hread(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk) bus <= '0;
		#1 d = rdata;
	endtask : hread
	// start a transfer, expect busy at once, wait it out, expect status equal to exp
	task automatic run(input logic [7:0] ctrl, input logic [7:0] exp);
		logic [7:0] d;
		hwrite(HA_CTRL, ctrl);
		#1 chk({7'h00, busy}, 8'h01);
		do begin
			@(posedge clk);
			#1;
		end while (busy !== 1'b0);
		hread(HA_STATUS, d);
		chk(d, exp);
	endtask : run
	task automatic t_reset;
		logic [7:0] d;
		hread(HA_STATUS, d);
		chk(d, 8'h00);
		hread(4'hf, d);
		chk(d, 8'h00);
	endtask : t_reset
	// status written with the power-on flag set; flag goes out as zero, value read back
	task automatic t_status;
		logic [7:0] d;
		hwrite(HA_POINTER, REG_STATUS_CONFIG);
		hwrite(HA_WDATA0, 8'h48);
		run(8'h01, 8'h04);
		chk(i_bmh_dev_model.regs[1], 8'h08);
		run(8'h03, 8'h04);
		hread(HA_RDATA0, d);
		chk(d, 8'h08);
	endtask : t_status
	task automatic t_past_top;
		logic [7:0] d;
		hwrite(HA_POINTER, 8'hff);
		run(8'h07, 8'h04);
		hread(HA_RDATA0, d);
		chk(d, 8'h00);
		hread(HA_RDATA1, d);
		chk(d, 8'hff);
	endtask : t_past_top
	// silent device: address not acknowledged, transfer must stop early
	task automatic t_no_ack;
		@(posedge clk) dev_mute <= 1'b1;
		hwrite(HA_POINTER, REG_CHARGE_HIGH);
		run(8'h01, 8'h06);
		@(posedge clk) dev_mute <= 1'b0;
		chk(i_bmh_dev_model.regs[16], 8'hc3);
	endtask : t_no_ack
	task automatic t_write_pair;
		hwrite(HA_POINTER, REG_CHARGE_HIGH);
		hwrite(HA_WDATA0, 8'hc3);
		hwrite(HA_WDATA1, 8'h3c);
		run(8'h05, 8'h04);
		chk(i_bmh_dev_model.regs[16], 8'hc3);
		chk(i_bmh_dev_model.regs[17], 8'h3c);
	endtask : t_write_pair
	task automatic t_read_pair;
		logic [7:0] d;
		hwrite(HA_POINTER, REG_CHARGE_HIGH);
		run(8'h07, 8'h04);
		hread(HA_RDATA0, d);
		chk(d, 8'hc3);
		hread(HA_RDATA1, d);
		chk(d, 8'h3c);
	endtask : t_read_pair
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// all transfers together take about 68k cycles; beyond this something hangs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			fail_count = fail_count + 1;
			end_of_test();
		end
	end
	initial begin
		resetn = 1'b0;
		bus = '0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_write_pair();
		t_read_pair();
		t_status();
		t_past_top();
		t_no_ack();
		end_of_test();
	end
endmodule : bmh_master_bench

// ==== bmh_master_chk.sv ====
// bmh_master_chk: assertions on the ports of bmh_master.
// assumes the bind below; sees the top ports only.
`timescale 1ns/10ps
module bmh_master_chk import bmh_pkg::*; (
	input wire logic         clk,
	input wire logic         resetn,
	input wire bmh_bus_type  bus,
	input wire logic [7:0]   rdata,
	input wire logic         scl_i,
	input wire logic         sda_i,
	input wire bmh_pins_type pins,
	input wire logic         busy
);
	int   run_r;
	logic prev_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// length of the last scl level; a short level would break bus timing
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			run_r  <= 0;
			prev_r <= 1'b0;
		end else begin
			run_r  <= (pins.scl_oe != prev_r) ? 1 : run_r + 1;
			prev_r <= pins.scl_oe;
		end
	end
	a_open_drain: assert property (!pins.scl_o && !pins.sda_o)
		else $error("pin driven high");
	a_scl_level_min: assert property (
		busy && pins.scl_oe != prev_r |-> run_r >= QUARTER_CYC - 1) else $error("scl level short");
	a_sda_setup: assert property (
		busy && $changed(pins.sda_oe) |-> $stable(pins.scl_oe)) else $error("sda moved with scl");
	a_idle_released: assert property (
		!busy && !$past(busy) |-> !pins.scl_oe && !pins.sda_oe) else $error("lines held idle");
	a_start_soon: assert property (
		$rose(busy) |-> ##[0:700] pins.sda_oe && !pins.scl_oe) else $error("no start");
	a_rdata_quiet: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("rdata outside read slot");
	a_status_busy: assert property (
		bus.rd && bus.addr == HA_STATUS |=> rdata[ST_BUSY] == $past(busy)) else $error("status busy");
	a_go_busy: assert property (
		bus.wr && bus.addr == HA_CTRL && bus.wdata[CTRL_GO] && !busy |=> busy) else $error("no busy");
	c_done: cover property ($fell(busy));
	c_start: cover property ($rose(pins.sda_oe) && !pins.scl_oe);
	c_low_read: cover property (bus.rd && bus.addr == HA_RDATA1);
endmodule : bmh_master_chk
bind bmh_master bmh_master_chk i_bmh_master_chk (.clk(clk), .resetn(resetn), .bus(bus),
	.rdata(rdata), .scl_i(scl_i), .sda_i(sda_i), .pins(pins), .busy(busy));

// ==== bmh_pkg.sv ====
// bmh_pkg: constants and types for the two-wire master that talks to the battery monitor.
// assumes an external pull-up on both bus lines; the device answers as a slave only.
// How it works
// - host reads both bytes in one command
// - power-on flag written to zero in wd0 when the pointer is on status
// - check aux valid before reading aux results; not done here, nothing tests SC_AUX0_VALID or SC_AUX1_VALID
// - host makes clock, start and stop
// - data changes only while clock low
// - start falls, stop rises, repeated start allowed
// - receiver acks low across ninth pulse
// - nack leaves data released on ninth pulse
// - host stops and flags nack after missing acknowledge, no retry
// - eight bits msb first, then acknowledge
// - direction 0 writes, 1 reads
// - read is S,addr+W,ptr,Sr,addr+R,data,N,P
package bmh_pkg;
	// ************************************************
	// bus timing
	// ************************************************
	localparam int CLK_PERIOD_NS     = 8;
	localparam int SCL_PERIOD_NS     = 2500;
	localparam int QUARTER_NS        = SCL_PERIOD_NS / 4;
	localparam int QUARTER_CYC       = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int QCNT_W            = 8;
	// address of the device; value arbitrary
	localparam logic [6:0] DEV_ADDR  = 7'h2a;
	localparam logic RW_WRITE        = 1'b0;
	localparam logic RW_READ         = 1'b1;
	// ************************************************
	// device register map
	// ************************************************
	localparam logic [7:0] REG_STATUS_CONFIG = 8'h01;
	localparam logic [7:0] REG_AUX0_HIGH     = 8'h08;
	localparam logic [7:0] REG_AUX0_LOW      = 8'h09;
	localparam logic [7:0] REG_AUX1_HIGH     = 8'h0a;
	localparam logic [7:0] REG_AUX1_LOW      = 8'h0b;
	localparam logic [7:0] REG_VOLT_HIGH     = 8'h0c;
	localparam logic [7:0] REG_VOLT_LOW      = 8'h0d;
	localparam logic [7:0] REG_CURR_HIGH     = 8'h0e;
	localparam logic [7:0] REG_CURR_LOW      = 8'h0f;
	localparam logic [7:0] REG_CHARGE_HIGH   = 8'h10;
	localparam logic [7:0] REG_CHARGE_LOW    = 8'h11;
	localparam logic [7:0] REG_OFFSET_TRIM   = 8'h61;
	localparam logic [7:0] REG_ACC_TRIM      = 8'h62;
	localparam int SC_POWER_ON_FLAG  = 6;
	localparam int SC_SLEEP_ALLOW    = 5;
	localparam int SC_NEG_BLANK      = 4;
	localparam int SC_DIV_OFF        = 3;
	localparam int SC_AUX1_VALID     = 1;
	localparam int SC_AUX0_VALID     = 0;
	localparam logic [7:0] SC_WRITE_MASK = 8'h78;
	// ************************************************
	// host command registers
	// ************************************************
	localparam logic [3:0] HA_CTRL    = 4'h0;
	localparam logic [3:0] HA_POINTER = 4'h1;
	localparam logic [3:0] HA_WDATA0  = 4'h2;
	localparam logic [3:0] HA_WDATA1  = 4'h3;
	localparam logic [3:0] HA_STATUS  = 4'h4;
	localparam logic [3:0] HA_RDATA0  = 4'h5;
	localparam logic [3:0] HA_RDATA1  = 4'h6;
	localparam int CTRL_GO     = 0;
	localparam int CTRL_READ   = 1;
	localparam int CTRL_TWO    = 2;
	localparam int ST_BUSY     = 0;
	localparam int ST_NACK     = 1;
	localparam int ST_DONE     = 2;

	typedef enum {
		BM_IDLE, BM_START, BM_BIT, BM_ACK, BM_RSTART, BM_STOP
	} bmh_state_type;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bmh_bus_type;

	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} bmh_pins_type;
endpackage : bmh_pkg
